/* parallel_result_output.sv */
// Purpose: Parallel result output toward an external controller
// Assumes: Results arrive as one-cycle pulses from the measurement side
// Notes:   Settings take effect on cfgLoad; times counted in 0.1 ms ticks
`timescale 1ns/1ps
`include "pro_map.svh"
module parallel_result_output #(
    parameter int unsigned TICK_CYCLES = `PRO_TICK_NS / `PRO_CLK_NS
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             trigger_in,
    input  wire logic             receiver_ready_in,
    input  wire logic             settingsEdit,
    input  wire logic             cfgLoad,
    input  wire pro_pkg::pro_mode_type cfgMode,
    input  wire logic             cfgPolarityOk,
    input  wire logic             cfgOneShot,
    input  wire logic [15:0]      cfgPeriod,
    input  wire logic [13:0]      cfgGateDelay,
    input  wire logic [13:0]      cfgGateTime,
    input  wire logic [20:0]      cfgTimeout,
    input  wire logic [3:0]       skipped_trigger_count,
    input  wire logic [13:0]      cfgFlagTime,
    input  wire logic             resultValid,
    input  wire logic             resultNg,
    input  wire logic [15:0]      resultData,
    input  wire logic             errorClear,
    output logic                  measureStart_q,
    output logic [15:0]           result_data_out,
    output logic                  judgeFlag_q,
    output logic                  resultStrobe_q,
    output logic                  timeoutError_q,
    output logic                  triggerState,
    output logic                  readyState
);
    import pro_pkg::*;

    function automatic logic reached(input logic [20:0] cnt,
                                     input logic [20:0] lim);
        reached = (cnt == lim);
    endfunction

    pro_mode_type  mode_q;
    pro_state_type st_q;
    pro_state_type st_d;
    logic        polOk_q;
    logic        oneShot_q;
    logic [15:0] period_q;
    logic [13:0] delay_q;
    logic [13:0] onTime_q;
    logic [20:0] timeout_q;
    logic [3:0]  skip_q;
    logic [13:0] flagTime_q;
    logic [31:0] phasePre_q;
    logic [31:0] perPre_q;
    logic [20:0] phaseCnt_q;
    logic [15:0] perCnt_q;
    logic [13:0] flagCnt_q;
    logic [3:0]  syncCnt_q;
    logic [15:0] data_q;
    logic [16:0] qMem_q [`PRO_Q_DEPTH];
    logic [`PRO_Q_AW:0] wrPtr_q;
    logic [`PRO_Q_AW:0] rdPtr_q;
    logic        trigLvl;
    logic        trigRise;
    logic        readyLvl;

    pro_pin_sync u_trig (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .pinIn   (trigger_in),
        .level_q (trigLvl),
        .rise_q  (trigRise)
    );
    pro_pin_sync u_ready (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .pinIn   (receiver_ready_in),
        .level_q (readyLvl),
        .rise_q  ()
    );

    // Trigger and ready inputs are ignored while editing, states still visible
    assign triggerState = trigLvl;
    assign readyState   = readyLvl;
    wire trigUse  = trigRise && !settingsEdit;
    wire readyUse = readyLvl && !settingsEdit;

    wire mFree = (mode_q == PRO_MODE_FREE);
    wire mHs   = (mode_q == PRO_MODE_HS);
    wire mSync = (mode_q == PRO_MODE_SYNC);

    wire phaseTick = (phasePre_q == TICK_CYCLES - 1);
    wire perTick   = (perPre_q == TICK_CYCLES - 1);

    // Result queue
    wire qEmpty = (wrPtr_q == rdPtr_q);
    wire qFull  = (wrPtr_q[`PRO_Q_AW] != rdPtr_q[`PRO_Q_AW]) &&
                  (wrPtr_q[`PRO_Q_AW-1:0] == rdPtr_q[`PRO_Q_AW-1:0]);
    wire qWr    = resultValid && !qFull;
    wire [16:0] qHead = qMem_q[rdPtr_q[`PRO_Q_AW-1:0]];

    // Start conditions per mode
    wire periodDone = (perCnt_q >= period_q);
    wire startFree  = mFree && !qEmpty && periodDone;
    wire syncHit    = (syncCnt_q == skip_q);
    wire startSync  = mSync && !qEmpty && trigUse && syncHit;
    wire toHit      = mHs && reached(phaseCnt_q, timeout_q);
    wire settleDone = reached(phaseCnt_q, {7'h00, delay_q});
    wire onDone     = reached(phaseCnt_q, {7'h00, onTime_q});
    wire strobeEnd  = mHs ? (!readyUse || toHit) : onDone;
    wire errSet     = toHit &&
                      (st_q == PRO_ST_WAIT || st_q == PRO_ST_STROBE);
    wire phaseNew   = (st_d != st_q);
    wire load       = (st_q != PRO_ST_SETTLE) && (st_d == PRO_ST_SETTLE);
    wire flagAct    = polOk_q ? !qHead[`PRO_Q_NG] : qHead[`PRO_Q_NG];
    wire flagEnd    = oneShot_q && (flagCnt_q == flagTime_q);
    wire [3:0] skipIn = (skipped_trigger_count == 4'h0) ? 4'h1
                        : skipped_trigger_count;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            PRO_ST_IDLE: begin
                if (startFree || startSync) begin
                    st_d = PRO_ST_SETTLE;
                end else if (mHs && !qEmpty) begin
                    st_d = PRO_ST_WAIT;
                end
            end
            PRO_ST_WAIT: begin
                if (toHit || !mHs) begin
                    st_d = PRO_ST_IDLE;
                end else if (readyUse) begin
                    st_d = PRO_ST_SETTLE;
                end
            end
            PRO_ST_SETTLE: begin
                if (settleDone) begin
                    st_d = PRO_ST_STROBE;
                end
            end
            PRO_ST_STROBE: begin
                if (strobeEnd) begin
                    st_d = PRO_ST_IDLE;
                end
            end
            default: st_d = PRO_ST_IDLE;
        endcase
    end

    // Configuration with reset defaults
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mode_q     <= PRO_MODE_FREE;
            polOk_q    <= 1'b0;
            oneShot_q  <= 1'b0;
            period_q   <= `PRO_DEF_PERIOD;
            delay_q    <= `PRO_DEF_DELAY;
            onTime_q   <= `PRO_DEF_ONTIME;
            timeout_q  <= `PRO_DEF_TIMEOUT;
            skip_q     <= `PRO_DEF_SKIP;
            flagTime_q <= `PRO_DEF_FLAGTIME;
        end else if (cfgLoad) begin
            mode_q     <= cfgMode;
            polOk_q    <= cfgPolarityOk;
            oneShot_q  <= cfgOneShot;
            period_q   <= cfgPeriod;
            delay_q    <= cfgGateDelay;
            onTime_q   <= cfgGateTime;
            timeout_q  <= cfgTimeout;
            skip_q     <= skipIn;
            flagTime_q <= cfgFlagTime;
        end
    end

    // Queue storage, one entry per index
    genvar gi;
    generate
        for (gi = 0; gi < `PRO_Q_DEPTH; gi++) begin : g_q
            always_ff @(posedge ref_clk) begin
                if (qWr && wrPtr_q[`PRO_Q_AW-1:0] == gi) begin
                    qMem_q[gi] <= {resultNg, resultData};
                end
            end
        end
    endgenerate

    // Timers and sequencer
    // Prescalers restart at one, so each phase lasts whole ticks
    // Needs TICK_CYCLES of two or more
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_q       <= PRO_ST_IDLE;
            wrPtr_q    <= '0;
            rdPtr_q    <= '0;
            phasePre_q <= 32'h0;
            perPre_q   <= 32'h0;
            phaseCnt_q <= 21'h0;
            perCnt_q   <= 16'h0;
            flagCnt_q  <= 14'h0;
            syncCnt_q  <= 4'h0;
        end else begin
            st_q       <= st_d;
            wrPtr_q    <= wrPtr_q + (`PRO_Q_AW+1)'(qWr);
            rdPtr_q    <= rdPtr_q + (`PRO_Q_AW+1)'(load);
            phasePre_q <= phaseNew ? 32'h1
                          : (phaseTick ? 32'h0 : phasePre_q + 32'h1);
            perPre_q   <= load ? 32'h1
                          : (perTick ? 32'h0 : perPre_q + 32'h1);
            if (phaseNew) begin
                phaseCnt_q <= 21'h0;
            end else if (phaseTick) begin
                phaseCnt_q <= phaseCnt_q + 21'h1;
            end
            if (load) begin
                perCnt_q  <= 16'h0;
                flagCnt_q <= 14'h0;
            end else if (perTick) begin
                perCnt_q  <= periodDone ? perCnt_q : perCnt_q + 16'h1;
                flagCnt_q <= flagEnd ? flagCnt_q : flagCnt_q + 14'h1;
            end
            if (load || !mSync) begin
                syncCnt_q <= 4'h0;
            end else if (trigUse && !qEmpty) begin
                syncCnt_q <= syncCnt_q + 4'h1;
            end
        end
    end

    // Output registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            measureStart_q <= 1'b0;
            data_q         <= 16'h0;
            judgeFlag_q    <= 1'b0;
            resultStrobe_q <= 1'b0;
            timeoutError_q <= 1'b0;
        end else begin
            measureStart_q <= trigUse;
            data_q         <= load ? (flagAct ? qHead[15:0] : 16'h0)
                              : data_q;
            judgeFlag_q    <= load ? flagAct
                              : (flagEnd ? 1'b0 : judgeFlag_q);
            resultStrobe_q <= (st_d == PRO_ST_STROBE);
            timeoutError_q <= errSet || (timeoutError_q && !errorClear);
        end
    end
    assign result_data_out = data_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    data_stable_a: assert property (
        resultStrobe_q && $past(resultStrobe_q) |-> $stable(data_q))
        else $error("Result data changed while strobe high");
    settle_delay_a: assert property (
        $rose(resultStrobe_q) |-> $past(st_q == PRO_ST_SETTLE && settleDone))
        else $error("Strobe rose before settle delay ended");
    on_time_a: assert property (
        $fell(resultStrobe_q) && !$past(mHs) |-> $past(onDone))
        else $error("Strobe on-time wrong");
    free_start_a: assert property (
        st_q == PRO_ST_IDLE && startFree |=> st_q == PRO_ST_SETTLE)
        else $error("Free-running output waited");
    hs_ready_a: assert property (
        st_q == PRO_ST_WAIT && !readyUse |=> st_q != PRO_ST_SETTLE)
        else $error("Handshake output without ready");
    sync_trigger_a: assert property (
        mSync && st_q == PRO_ST_IDLE ##1 st_q == PRO_ST_SETTLE
        |-> $past(trigUse && syncHit))
        else $error("Synchronised output off trigger");
    timeout_err_a: assert property (
        $rose(timeoutError_q) |-> $past(mHs && errSet))
        else $error("Timeout error outside handshake");
    edit_ignore_a: assert property (
        settingsEdit && trigRise |=> !measureStart_q)
        else $error("Trigger taken while editing");
    skip_range_a: assert property (
        skip_q != 4'h0)
        else $error("Skip count out of range");
    polarity_a: assert property (
        load |=> judgeFlag_q == $past(flagAct))
        else $error("Judgement flag polarity wrong");

    cover_free_c: cover property (mFree ##1 $rose(resultStrobe_q));
    cover_hs_c:   cover property (mHs && $fell(resultStrobe_q));
    cover_sync_c: cover property (mSync && load);
    cover_to_c:   cover property ($rose(timeoutError_q));
endmodule

/* pro_map.svh */
// Purpose: Constants for the parallel result output block
// Assumes: 100 MHz ref_clk, 0.1 ms time base for all time settings
// Notes:   Time settings are held in 0.1 ms ticks, timeout included
`ifndef PRO_MAP_SVH
`define PRO_MAP_SVH
`define PRO_CLK_NS        10
`define PRO_TICK_NS       100000
`define PRO_DEF_PERIOD    16'h0064
`define PRO_DEF_DELAY     14'h000a
`define PRO_DEF_ONTIME    14'h0032
`define PRO_DEF_TIMEOUT   21'h0186a0
`define PRO_DEF_FLAGTIME  14'h0032
`define PRO_DEF_SKIP      4'h1
`define PRO_Q_NG          16
`define PRO_Q_AW          2
`define PRO_Q_DEPTH       4
`endif

/* pro_pkg.sv */
// Purpose: Types for the parallel result output block
// Assumes: Nothing beyond the map header
// Notes:   States are one-hot
package pro_pkg;
    typedef enum logic [1:0] {
        PRO_MODE_FREE = 2'h0,
        PRO_MODE_HS   = 2'h1,
        PRO_MODE_SYNC = 2'h2
    } pro_mode_type;
    typedef enum logic [3:0] {
        PRO_ST_IDLE   = 4'h1,
        PRO_ST_WAIT   = 4'h2,
        PRO_ST_SETTLE = 4'h4,
        PRO_ST_STROBE = 4'h8
    } pro_state_type;
endpackage

/* pro_pin_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to ref_clk
// Notes:   Level changes once stages two and three agree
`timescale 1ns/1ps
module pro_pin_sync (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic pinIn,
    output logic      level_q,
    output logic      rise_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    wire  agree = (s2_q == s3_q);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            s1_q    <= pinIn;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= agree ? s3_q : level_q;
            rise_q  <= agree && s3_q && !level_q;
        end
    end
endmodule

/* pro_plc_model.sv */
// Purpose: Controller model driving trigger and ready pins
// Assumes: Pins are sampled through the block's synchroniser
// Notes:   Ready drops a few cycles after the strobe is seen
`timescale 1ns/1ps
module pro_plc_model (
    input  wire logic        ref_clk,
    input  wire logic        readyEn,
    input  wire logic        resultStrobe_q,
    input  wire logic [15:0] result_data_out,
    output logic             trigger_in,
    output logic             receiver_ready_in,
    output logic [15:0]      capData
);
    int lag = 0;
    initial begin
        trigger_in = 1'b0;
        receiver_ready_in = 1'b0;
        capData = 16'h0000;
    end
    // Ready while able to take a result, dropped once captured
    always @(negedge ref_clk) begin
        if (readyEn !== 1'b1) begin
            receiver_ready_in <= 1'b0;
            lag <= 0;
        end else if (resultStrobe_q === 1'b1) begin
            if (lag == 0)
                capData <= result_data_out;
            lag <= lag + 1;
            if (lag >= 2)
                receiver_ready_in <= 1'b0;
        end else begin
            lag <= 0;
            receiver_ready_in <= 1'b1;
        end
    end
    // One trigger pulse, high and low long enough to be seen
    task automatic fire();
        @(negedge ref_clk);
        trigger_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        trigger_in = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule

/* parallel_result_output_tb.sv */
// Purpose: Self-checking bench for the parallel result output
// Assumes: Tick shortened to TK cycles
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
`include "pro_map.svh"
module parallel_result_output_tb;
    import pro_pkg::*;
    localparam int TK = 4;
    logic         ref_clk               = 1'b0;
    logic         reset_n               = 1'b0;
    logic         readyEn               = 1'b0;
    logic         settingsEdit          = 1'b0;
    logic         cfgLoad               = 1'b0;
    pro_mode_type cfgMode               = PRO_MODE_FREE;
    logic         cfgPolarityOk         = 1'b0;
    logic         cfgOneShot            = 1'b0;
    logic [15:0]  cfgPeriod             = `PRO_DEF_PERIOD;
    logic [13:0]  cfgGateDelay          = `PRO_DEF_DELAY;
    logic [13:0]  cfgGateTime           = `PRO_DEF_ONTIME;
    logic [20:0]  cfgTimeout            = `PRO_DEF_TIMEOUT;
    logic [3:0]   skipped_trigger_count = `PRO_DEF_SKIP;
    logic [13:0]  cfgFlagTime           = `PRO_DEF_FLAGTIME;
    logic         resultValid           = 1'b0;
    logic         resultNg              = 1'b0;
    logic [15:0]  resultData            = 16'h0000;
    logic         errorClear            = 1'b0;
    logic         measureStart_q, judgeFlag_q, resultStrobe_q;
    logic         timeoutError_q, triggerState, readyState;
    logic         trigger_in, receiver_ready_in;
    logic [15:0]  result_data_out, capData;
    int           err_count = 0;
    int           checked   = 0;
    int           starts    = 0;
    int           n;
    int           k;
    always #5 ref_clk = ~ref_clk;
    parallel_result_output #(.TICK_CYCLES(TK)) dut (.ref_clk, .reset_n,
        .trigger_in, .receiver_ready_in, .settingsEdit, .cfgLoad,
        .cfgMode, .cfgPolarityOk, .cfgOneShot, .cfgPeriod, .cfgGateDelay,
        .cfgGateTime, .cfgTimeout, .skipped_trigger_count, .cfgFlagTime,
        .resultValid, .resultNg, .resultData, .errorClear,
        .measureStart_q, .result_data_out, .judgeFlag_q, .resultStrobe_q,
        .timeoutError_q, .triggerState, .readyState);
    pro_plc_model u_plc (.ref_clk, .readyEn, .resultStrobe_q,
        .result_data_out, .trigger_in, .receiver_ready_in, .capData);
    always @(posedge ref_clk)
        if (measureStart_q === 1'b1)
            starts <= starts + 1;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge ref_clk);
    endtask
    // Cycles until the strobe reaches lvl, bounded
    task automatic waitStb(input logic lvl, output int c);
        c = 0;
        while (resultStrobe_q !== lvl && c < 3000) begin
            tick(1);
            c++;
        end
    endtask
    task automatic waitData(input logic [15:0] v);
        for (int i = 0; i < 3000 && result_data_out !== v; i++)
            tick(1);
    endtask
    task automatic load();
        tick(1);
        cfgLoad = 1'b1;
        tick(1);
        cfgLoad = 1'b0;
    endtask
    task automatic push(input logic ng, input logic [15:0] d);
        tick(1);
        resultValid = 1'b1;
        resultNg = ng;
        resultData = d;
        tick(1);
        resultValid = 1'b0;
    endtask
    task automatic t_default();
        push(1'b1, 16'h1234);
        waitData(16'h1234);
        waitStb(1'b1, n);
        chk(16'(n), 16'(10 * TK));
        chk(result_data_out, 16'h1234);
        waitStb(1'b0, n);
        chk(16'(n), 16'(50 * TK));
        chk(result_data_out, 16'h1234);
        chk(judgeFlag_q, 1'b1);
        $display("t_default done");
    endtask
    task automatic t_polarity();
        cfgPolarityOk = 1'b1;
        cfgOneShot = 1'b1;
        cfgFlagTime = 14'h0002;
        cfgPeriod = 16'h001e;
        cfgGateTime = 14'h000a;
        load();
        push(1'b0, 16'h55aa);
        waitData(16'h55aa);
        chk(judgeFlag_q, 1'b1);
        tick(2 * TK + 2);
        chk(judgeFlag_q, 1'b0);
        waitStb(1'b1, n);
        waitStb(1'b0, n);
        push(1'b1, 16'h7777);
        waitStb(1'b1, n);
        chk(result_data_out, 16'h0000);
        chk(judgeFlag_q, 1'b0);
        waitStb(1'b0, n);
        $display("t_polarity done");
    endtask
    task automatic t_period();
        cfgPolarityOk = 1'b0;
        cfgOneShot = 1'b0;
        load();
        push(1'b1, 16'h0a01);
        push(1'b1, 16'h0a02);
        waitStb(1'b1, n);
        chk(result_data_out, 16'h0a01);
        waitStb(1'b0, n);
        waitStb(1'b1, k);
        chk(16'(n + k), 16'(30 * TK));
        chk(result_data_out, 16'h0a02);
        waitStb(1'b0, n);
        $display("t_period done");
    endtask
    task automatic t_hand();
        cfgMode = PRO_MODE_HS;
        cfgTimeout = 21'h00001e;
        load();
        push(1'b1, 16'hc0de);
        tick(60);
        chk(resultStrobe_q, 1'b0);
        readyEn = 1'b1;
        waitStb(1'b1, n);
        chk(readyState, 1'b1);
        waitStb(1'b0, n);
        chk(capData, 16'hc0de);
        readyEn = 1'b0;
        tick(10);
        push(1'b1, 16'hbeef);
        tick(30 * TK + 20);
        chk(timeoutError_q, 1'b1);
        chk(resultStrobe_q, 1'b0);
        errorClear = 1'b1;
        tick(1);
        errorClear = 1'b0;
        tick(1);
        chk(timeoutError_q, 1'b0);
        readyEn = 1'b1;
        waitStb(1'b1, n);
        waitStb(1'b0, n);
        chk(capData, 16'hbeef);
        readyEn = 1'b0;
        $display("t_hand done");
    endtask
    task automatic t_sync();
        cfgMode = PRO_MODE_SYNC;
        skipped_trigger_count = 4'h2;
        load();
        settingsEdit = 1'b1;
        k = starts;
        fork
            u_plc.fire();
            begin
                tick(6);
                chk(triggerState, 1'b1);
            end
        join
        chk(16'(starts - k), 16'h0000);
        settingsEdit = 1'b0;
        push(1'b1, 16'h0f0f);
        u_plc.fire();
        u_plc.fire();
        chk(resultStrobe_q, 1'b0);
        chk(16'(starts - k), 16'h0002);
        u_plc.fire();
        waitStb(1'b1, n);
        chk(result_data_out, 16'h0f0f);
        waitStb(1'b0, n);
        chk(16'(n), 16'(10 * TK));
        $display("t_sync done");
    endtask
    initial begin
        tick(30000);
        err_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
        stop_test();
    end
    initial begin
        tick(8);
        reset_n = 1'b1;
        t_default();
        t_polarity();
        t_period();
        t_hand();
        t_sync();
        stop_test();
    end
endmodule
